// ===== logic/t2c_params.svh
`ifndef T2C_PARAMS_SVH
`define T2C_PARAMS_SVH

// register indices; byte address is four times the index
`define T2C_IDX_CLKCTL 10'h08F
`define T2C_IDX_CTRL_BIT 10'h0C7
`define T2C_IDX_CTRL 10'h0C8
`define T2C_IDX_MODE 10'h0C9
`define T2C_IDX_RCAP_LO 10'h0CA
`define T2C_IDX_RCAP_HI 10'h0CB
`define T2C_IDX_CNT_LO 10'h0CC
`define T2C_IDX_CNT_HI 10'h0CD
`define T2C_IDX_IRQ_STAT 10'h0D0
`define T2C_IDX_IRQ_MASK 10'h0D1

// timer_two_control bit positions
`define T2C_BIT_OVF 7
`define T2C_BIT_EXT 6
`define T2C_BIT_RXSEL 5
`define T2C_BIT_TXSEL 4
`define T2C_BIT_TRIGEN 3
`define T2C_BIT_RUN 2
`define T2C_BIT_CT 1
`define T2C_BIT_CPRL 0

// timer_two_mode_control bit positions
`define T2C_BIT_CLKOE 1
`define T2C_BIT_UPDN 0

// core_clock_control bit position
`define T2C_BIT_DBL 0

// interrupt status and mask bit positions
`define T2C_IRQ_OVF 0
`define T2C_IRQ_EXT 1

// reset values
`define T2C_RST_CTRL 8'h00
`define T2C_RST_MODE 8'h00
`define T2C_RST_CLKCTL 8'h00
`define T2C_RST_WORD 16'h0000
`define T2C_RST_MASK 2'h0

// oscillator clocks per machine cycle
`define T2C_NORM_CLKS 4'hC
`define T2C_DBL_CLKS 4'h6

`endif

// ===== logic/t2c_pkg.sv
package t2c_pkg;

    // register selected by an APB address
    typedef enum logic [3:0] {
        T2C_SEL_NONE,
        T2C_SEL_CLKCTL,
        T2C_SEL_CTRL_BIT,
        T2C_SEL_CTRL,
        T2C_SEL_MODE,
        T2C_SEL_RCAP_LO,
        T2C_SEL_RCAP_HI,
        T2C_SEL_CNT_LO,
        T2C_SEL_CNT_HI,
        T2C_SEL_IRQ_STAT,
        T2C_SEL_IRQ_MASK
    } t2c_sel_type;

    // pin identities for the synchroniser array
    typedef enum logic {
        T2C_PIN_COUNT,
        T2C_PIN_TRIG
    } t2c_pin_type;

endpackage

// ===== logic/t2c_pin_if.sv
`timescale 1ns/10ps
`default_nettype none

interface t2c_pin_if;
    logic raw;
    logic level;
    logic fall;

    modport sync (
        input raw,
        output level,
        output fall
    );
    modport user (
        output raw,
        input level,
        input fall
    );
endinterface

`default_nettype wire

// ===== logic/t2c_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module t2c_pin_sync (
    input wire logic clk_in,
    input wire logic rst_n_in,
    t2c_pin_if.sync pin
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // two-stage synchroniser, first stage read only by the second
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= pin.raw;
            sync_ff <= meta_ff;
        end
    end

    // previous sample for edge compare; idle-high pins so no false edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_ff <= 1'b1;
        end else begin
            prev_ff <= sync_ff;
        end
    end

    assign pin.level = sync_ff;
    assign pin.fall = prev_ff & ~sync_ff;
endmodule

`default_nettype wire

// ===== logic/t2c_timer.sv
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "t2c_params.svh"

module t2c_timer
    import t2c_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic COUNT_PIN_IN,
    input wire logic TRIGGER_PIN_IN,
    input wire logic TIMER1_OVF_IN,
    input wire logic SERIAL_MODE13_IN,
    output logic RX_BAUD_TICK_OUT,
    output logic TX_BAUD_TICK_OUT,
    output logic MACHINE_CYCLE_OUT,
    output logic CLOCK_OUT_OUT,
    output logic CLOCK_OUT_OE_OUT,
    output logic IRQ_OUT
);
    // register state
    logic [7:0] ctrl_ff;
    logic [7:0] mode_ff;
    logic [7:0] clkctl_ff;
    logic [15:0] rcap_ff;
    logic [15:0] cnt_ff;
    logic [1:0] mask_ff;
    logic [3:0] presc_ff;
    logic mc_tick_ff;
    logic clkout_ff;
    logic rx_tick_ff;
    logic tx_tick_ff;
    logic [31:0] rdata_ff;
    logic slverr_ff;

    // combinational terms
    logic [7:0] nxt_ctrl;
    logic [15:0] nxt_cnt;
    logic [15:0] nxt_rcap;
    logic [3:0] presc_limit;
    logic setup_phase;
    logic wr_access;
    t2c_sel_type sel_setup;
    t2c_sel_type sel_access;
    logic [7:0] wbyte;
    logic [7:0] ctrl_wmask;
    logic [7:0] ctrl_wval;
    logic [1:0] irq_w1c;
    logic baud_mode;
    logic capture_mode;
    logic updown_mode;
    logic count_up;
    logic tick;
    logic ovf_up;
    logic ovf_dn;
    logic ovf;
    logic trig_evt;
    logic [1:0] irq_pend;
    logic [31:0] rd_mux;

    // one synchroniser per external pin
    t2c_pin_if pin_bus [2] ();

    assign pin_bus[T2C_PIN_COUNT].raw = COUNT_PIN_IN;
    assign pin_bus[T2C_PIN_TRIG].raw = TRIGGER_PIN_IN;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            t2c_pin_sync u_sync (
                .clk_in(CLK_IN),
                .rst_n_in(RST_N_IN),
                .pin(pin_bus[gi])
            );
        end
    endgenerate

    // address decode, shared by read and write phases
    function automatic t2c_sel_type reg_sel(input logic [11:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        unique case (idx)
            `T2C_IDX_CLKCTL: reg_sel = T2C_SEL_CLKCTL;
            `T2C_IDX_CTRL_BIT: reg_sel = T2C_SEL_CTRL_BIT;
            `T2C_IDX_CTRL: reg_sel = T2C_SEL_CTRL;
            `T2C_IDX_MODE: reg_sel = T2C_SEL_MODE;
            `T2C_IDX_RCAP_LO: reg_sel = T2C_SEL_RCAP_LO;
            `T2C_IDX_RCAP_HI: reg_sel = T2C_SEL_RCAP_HI;
            `T2C_IDX_CNT_LO: reg_sel = T2C_SEL_CNT_LO;
            `T2C_IDX_CNT_HI: reg_sel = T2C_SEL_CNT_HI;
            `T2C_IDX_IRQ_STAT: reg_sel = T2C_SEL_IRQ_STAT;
            `T2C_IDX_IRQ_MASK: reg_sel = T2C_SEL_IRQ_MASK;
            default: reg_sel = T2C_SEL_NONE;
        endcase
    endfunction

    // apb phases; slave never inserts wait states
    assign setup_phase = PSEL_IN & ~PENABLE_IN;
    assign wr_access = PSEL_IN & PENABLE_IN & PWRITE_IN;
    assign sel_setup = reg_sel(PADDR_IN);
    assign sel_access = reg_sel(PADDR_IN);
    assign wbyte = PWDATA_IN[7:0];
    assign PREADY_OUT = 1'b1;
    assign PRDATA_OUT = rdata_ff;
    assign PSLVERR_OUT = slverr_ff & PSEL_IN & PENABLE_IN;

    // control write: whole byte, or single bit via the bit port
    always_comb begin
        ctrl_wmask = 8'h00;
        ctrl_wval = 8'h00;
        irq_w1c = 2'h0;
        if (wr_access) begin
            unique case (sel_access)
                T2C_SEL_CTRL: begin
                    ctrl_wmask = 8'hFF;
                    ctrl_wval = wbyte;
                end
                T2C_SEL_CTRL_BIT: begin
                    ctrl_wmask = 8'h01 << wbyte[2:0];
                    ctrl_wval = {8{wbyte[3]}};
                end
                T2C_SEL_IRQ_STAT: irq_w1c = wbyte[1:0];
                default: ;
            endcase
        end
    end

    // mode decode from control and mode bits
    // serial clocking overrides the capture select
    assign baud_mode = ctrl_ff[`T2C_BIT_RXSEL] | ctrl_ff[`T2C_BIT_TXSEL];
    // capture only when not serial clocking
    assign capture_mode = ctrl_ff[`T2C_BIT_CPRL] & ~baud_mode;
    assign updown_mode = mode_ff[`T2C_BIT_UPDN] & ~capture_mode & ~baud_mode;
    // trigger level steers direction in up/down mode
    assign count_up = ~updown_mode | pin_bus[T2C_PIN_TRIG].level;

    assign tick = ctrl_ff[`T2C_BIT_RUN] &
        (ctrl_ff[`T2C_BIT_CT] ? pin_bus[T2C_PIN_COUNT].fall : mc_tick_ff);

    assign ovf_up = tick & count_up & (cnt_ff == 16'hFFFF);
    assign ovf_dn = tick & ~count_up & (cnt_ff == rcap_ff);
    assign ovf = ovf_up | ovf_dn;

    // trigger edge acts only when enabled, not serial clocking and not in up/down mode
    assign trig_evt = pin_bus[T2C_PIN_TRIG].fall & ctrl_ff[`T2C_BIT_TRIGEN] &
        ~baud_mode & ~updown_mode;

    // machine cycle length from the double-speed bit
    assign presc_limit = clkctl_ff[`T2C_BIT_DBL] ? (`T2C_DBL_CLKS - 4'h1) :
        (`T2C_NORM_CLKS - 4'h1);

    // machine-cycle prescaler
    // the same pulse times every peripheral on this core
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            presc_ff <= 4'h0;
            mc_tick_ff <= 1'b0;
        end else if (presc_ff >= presc_limit) begin
            presc_ff <= 4'h0;
            mc_tick_ff <= 1'b1;
        end else begin
            presc_ff <= presc_ff + 4'h1;
            mc_tick_ff <= 1'b0;
        end
    end

    assign MACHINE_CYCLE_OUT = mc_tick_ff;

    // control next value; hardware flag sets win over clears
    always_comb begin
        nxt_ctrl = (ctrl_ff & ~ctrl_wmask) | (ctrl_wval & ctrl_wmask);
        if (irq_w1c[`T2C_IRQ_OVF]) begin
            nxt_ctrl[`T2C_BIT_OVF] = 1'b0;
        end
        if (irq_w1c[`T2C_IRQ_EXT]) begin
            nxt_ctrl[`T2C_BIT_EXT] = 1'b0;
        end
        // overflow flag only when not serial clocking
        if (ovf & ~baud_mode) begin
            nxt_ctrl[`T2C_BIT_OVF] = 1'b1;
        end
        // external flag on trigger capture or reload
        if (trig_evt) begin
            nxt_ctrl[`T2C_BIT_EXT] = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ctrl_ff <= `T2C_RST_CTRL;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // mode, clock control and mask registers
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mode_ff <= `T2C_RST_MODE;
            clkctl_ff <= `T2C_RST_CLKCTL;
            mask_ff <= `T2C_RST_MASK;
        end else if (wr_access) begin
            if (sel_access == T2C_SEL_MODE) begin
                mode_ff <= {6'h00, wbyte[`T2C_BIT_CLKOE], wbyte[`T2C_BIT_UPDN]};
            end
            // double-speed bit, standard speed at reset
            if (sel_access == T2C_SEL_CLKCTL) begin
                clkctl_ff <= {7'h00, wbyte[`T2C_BIT_DBL]};
            end
            if (sel_access == T2C_SEL_IRQ_MASK) begin
                mask_ff <= wbyte[1:0];
            end
        end
    end

    // count next value; a software write wins over counting
    always_comb begin
        nxt_cnt = cnt_ff;
        if (wr_access && sel_access == T2C_SEL_CNT_LO) begin
            nxt_cnt = {cnt_ff[15:8], wbyte};
        end else if (wr_access && sel_access == T2C_SEL_CNT_HI) begin
            nxt_cnt = {wbyte, cnt_ff[7:0]};
        // reload on trigger edge in reload mode
        end else if (trig_evt && !capture_mode) begin
            nxt_cnt = rcap_ff;
        end else if (ovf_up) begin
            nxt_cnt = capture_mode ? 16'h0000 : rcap_ff;
        end else if (ovf_dn) begin
            nxt_cnt = 16'hFFFF;
        end else if (tick) begin
            nxt_cnt = count_up ? (cnt_ff + 16'h0001) : (cnt_ff - 16'h0001);
        end
    end

    // capture/reload word next value
    always_comb begin
        nxt_rcap = rcap_ff;
        if (wr_access && sel_access == T2C_SEL_RCAP_LO) begin
            nxt_rcap = {rcap_ff[15:8], wbyte};
        end else if (wr_access && sel_access == T2C_SEL_RCAP_HI) begin
            nxt_rcap = {wbyte, rcap_ff[7:0]};
        end else if (trig_evt && capture_mode) begin
            nxt_rcap = cnt_ff;
        end
    end

    // counter and capture/reload word
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cnt_ff <= `T2C_RST_WORD;
            rcap_ff <= `T2C_RST_WORD;
        end else begin
            cnt_ff <= nxt_cnt;
            rcap_ff <= nxt_rcap;
        end
    end

    // baud ticks for the serial port, modes 1 and 3 only
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rx_tick_ff <= 1'b0;
            tx_tick_ff <= 1'b0;
        end else begin
            rx_tick_ff <= SERIAL_MODE13_IN &
                (ctrl_ff[`T2C_BIT_RXSEL] ? ovf : TIMER1_OVF_IN);
            tx_tick_ff <= SERIAL_MODE13_IN &
                (ctrl_ff[`T2C_BIT_TXSEL] ? ovf : TIMER1_OVF_IN);
        end
    end

    assign RX_BAUD_TICK_OUT = rx_tick_ff;
    assign TX_BAUD_TICK_OUT = tx_tick_ff;

    // clock-out pin toggles on each overflow while enabled
    // counter source must stay off here; not enforced in hardware
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            clkout_ff <= 1'b0;
        end else if (!mode_ff[`T2C_BIT_CLKOE]) begin
            clkout_ff <= 1'b0;
        end else if (ovf) begin
            clkout_ff <= ~clkout_ff;
        end
    end

    assign CLOCK_OUT_OUT = clkout_ff;
    assign CLOCK_OUT_OE_OUT = mode_ff[`T2C_BIT_CLKOE];

    // interrupt: flags gated by mask
    // external flag requests when enabled
    // no external request in up/down mode
    assign irq_pend[`T2C_IRQ_OVF] = ctrl_ff[`T2C_BIT_OVF] & mask_ff[`T2C_IRQ_OVF];
    assign irq_pend[`T2C_IRQ_EXT] = ctrl_ff[`T2C_BIT_EXT] & mask_ff[`T2C_IRQ_EXT] &
        ~mode_ff[`T2C_BIT_UPDN];
    assign IRQ_OUT = |irq_pend;

    // read multiplexer; reserved bits read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (sel_setup)
            T2C_SEL_CLKCTL: rd_mux[7:0] = clkctl_ff;
            T2C_SEL_CTRL: rd_mux[7:0] = ctrl_ff;
            T2C_SEL_MODE: rd_mux[7:0] = mode_ff;
            T2C_SEL_RCAP_LO: rd_mux[7:0] = rcap_ff[7:0];
            T2C_SEL_RCAP_HI: rd_mux[7:0] = rcap_ff[15:8];
            T2C_SEL_CNT_LO: rd_mux[7:0] = cnt_ff[7:0];
            T2C_SEL_CNT_HI: rd_mux[7:0] = cnt_ff[15:8];
            T2C_SEL_IRQ_STAT: rd_mux[1:0] = {ctrl_ff[`T2C_BIT_EXT], ctrl_ff[`T2C_BIT_OVF]};
            T2C_SEL_IRQ_MASK: rd_mux[1:0] = mask_ff;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data latched in the setup cycle, error for unmapped address
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
        end else if (setup_phase) begin
            rdata_ff <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
            slverr_ff <= (sel_setup == T2C_SEL_NONE);
        end
    end
endmodule

`default_nettype wire

// ===== sim/t2c_timer_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "t2c_params.svh"

module t2c_timer_assertions (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic RX_BAUD_TICK_OUT,
    input wire logic TX_BAUD_TICK_OUT,
    input wire logic MACHINE_CYCLE_OUT,
    input wire logic CLOCK_OUT_OUT,
    input wire logic CLOCK_OUT_OE_OUT,
    input wire logic IRQ_OUT
);
    logic [9:0] idx;
    logic wr_acc;
    logic mapped;
    logic [1:0] mask_ff;
    logic updn_ff;

    // decode of the bus side
    assign idx = PADDR_IN[11:2];
    assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign mapped = idx inside {`T2C_IDX_CLKCTL, `T2C_IDX_CTRL_BIT, `T2C_IDX_CTRL,
        `T2C_IDX_MODE, `T2C_IDX_RCAP_LO, `T2C_IDX_RCAP_HI, `T2C_IDX_CNT_LO,
        `T2C_IDX_CNT_HI, `T2C_IDX_IRQ_STAT, `T2C_IDX_IRQ_MASK};

    // shadow copies, since mask and up/down bits are not visible at the pins
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mask_ff <= 2'h0;
            updn_ff <= 1'b0;
        end else if (wr_acc && idx == `T2C_IDX_IRQ_MASK) begin
            mask_ff <= PWDATA_IN[1:0];
        end else if (wr_acc && idx == `T2C_IDX_MODE) begin
            updn_ff <= PWDATA_IN[`T2C_BIT_UPDN];
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    chk_ready_always: assert property (PREADY_OUT)
        else $error("pready dropped");
    chk_err_unmapped: assert property (PSEL_IN && PENABLE_IN && !mapped |-> PSLVERR_OUT)
        else $error("unmapped access without slave error");
    chk_err_placed: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN && mapped == 1'b0)
        else $error("slave error out of place");
    chk_rdata_hold: assert property (!(PSEL_IN && !PENABLE_IN) |=> $stable(PRDATA_OUT))
        else $error("read data moved outside setup");
    chk_rdata_upper: assert property (PRDATA_OUT[31:8] == 24'h000000)
        else $error("upper read data not zero");
    chk_cycle_gap: assert property (MACHINE_CYCLE_OUT |=> !MACHINE_CYCLE_OUT [*5])
        else $error("machine cycles too close");
    chk_clkout_off: assert property (!CLOCK_OUT_OE_OUT [*2] |-> !CLOCK_OUT_OUT)
        else $error("clock out active while disabled");
    chk_irq_masked: assert property (mask_ff == 2'h0 |-> !IRQ_OUT)
        else $error("interrupt with all masked");
    chk_irq_updown: assert property (updn_ff && !mask_ff[0] |-> !IRQ_OUT)
        else $error("external flag interrupt in up/down mode");
    chk_tick_pulse: assert property (TX_BAUD_TICK_OUT |=> !TX_BAUD_TICK_OUT)
        else $error("transmit tick longer than one cycle");

    cover property ($rose(IRQ_OUT));
    cover property (RX_BAUD_TICK_OUT);
    cover property ($rose(CLOCK_OUT_OUT));
endmodule

bind t2c_timer t2c_timer_assertions chk (.CLK_IN, .RST_N_IN, .PSEL_IN, .PENABLE_IN,
    .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT,
    .RX_BAUD_TICK_OUT, .TX_BAUD_TICK_OUT, .MACHINE_CYCLE_OUT, .CLOCK_OUT_OUT,
    .CLOCK_OUT_OE_OUT, .IRQ_OUT);

`default_nettype wire

// ===== sim/t2c_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

module t2c_pin_model (
    input wire logic clk_in,
    output logic count_pin_out,
    output logic trig_pin_out
);
    // pins are pulled up, so they idle high
    initial begin
        count_pin_out = 1'b1;
        trig_pin_out = 1'b1;
    end

    // falling edges, each level held four clocks
    task automatic pulse_count(input int n);
        repeat (n) begin
            @(posedge clk_in) count_pin_out <= 1'b0;
            repeat (4) @(posedge clk_in);
            count_pin_out <= 1'b1;
            repeat (4) @(posedge clk_in);
        end
    endtask

    // trigger level held, steers direction in up/down mode
    task automatic set_trigger(input logic v);
        @(posedge clk_in) trig_pin_out <= v;
        repeat (4) @(posedge clk_in);
    endtask

    // one slow falling edge on the trigger pin
    task automatic fall_trigger();
        @(posedge clk_in) trig_pin_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        trig_pin_out <= 1'b1;
        repeat (4) @(posedge clk_in);
    endtask
endmodule

`default_nettype wire

// ===== sim/timer_two_capture_reload_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "t2c_params.svh"

`define T2C_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end

module timer_two_capture_reload_tb;
    localparam logic [11:0] CK = {`T2C_IDX_CLKCTL, 2'b00}, CB = {`T2C_IDX_CTRL_BIT, 2'b00};
    localparam logic [11:0] CT = {`T2C_IDX_CTRL, 2'b00}, MD = {`T2C_IDX_MODE, 2'b00};
    localparam logic [11:0] RL = {`T2C_IDX_RCAP_LO, 2'b00}, RH = {`T2C_IDX_RCAP_HI, 2'b00};
    localparam logic [11:0] CL = {`T2C_IDX_CNT_LO, 2'b00}, CH = {`T2C_IDX_CNT_HI, 2'b00};
    localparam logic [11:0] ST = {`T2C_IDX_IRQ_STAT, 2'b00}, MK = {`T2C_IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] Z = 12'h000;
    typedef struct packed {
        logic [11:0] wa;
        logic [7:0] wd;
        logic [11:0] ra;
        logic [7:0] exp;
        logic err;
    } t2c_row_type;
    // rows writing to Z only read; that write is refused anyway
    t2c_row_type rows [13] = '{'{Z, 8'h00, CT, 8'h00, 1'b0}, '{Z, 8'h00, MD, 8'h00, 1'b0},
        '{Z, 8'h00, CK, 8'h00, 1'b0}, '{Z, 8'h00, MK, 8'h00, 1'b0},
        '{MD, 8'hFF, MD, 8'h03, 1'b0}, '{MD, 8'h00, MD, 8'h00, 1'b0},
        '{CK, 8'hFF, CK, 8'h01, 1'b0}, '{CK, 8'h00, CK, 8'h00, 1'b0},
        '{CB, 8'h0C, CT, 8'h10, 1'b0}, '{CB, 8'h04, CT, 8'h00, 1'b0},
        '{RL, 8'h5A, RL, 8'h5A, 1'b0}, '{CH, 8'hC3, CH, 8'hC3, 1'b0},
        '{Z, 8'h00, 12'hFFC, 8'h00, 1'b1}};
    logic clk, rst_n, psel, penable, pwrite, t1_ovf, mode13;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, count_pin, trig_pin, rx_tick, tx_tick, mc, clk_out, clk_oe, irq;
    logic [7:0] q;
    logic e;
    int error_cnt = 0;
    int num_checks = 0;
    int rx_cnt = 0;
    int tx_cnt = 0;
    int r0, t0, n;

    t2c_timer uut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .COUNT_PIN_IN(count_pin),
        .TRIGGER_PIN_IN(trig_pin), .TIMER1_OVF_IN(t1_ovf), .SERIAL_MODE13_IN(mode13),
        .RX_BAUD_TICK_OUT(rx_tick), .TX_BAUD_TICK_OUT(tx_tick), .MACHINE_CYCLE_OUT(mc),
        .CLOCK_OUT_OUT(clk_out), .CLOCK_OUT_OE_OUT(clk_oe), .IRQ_OUT(irq));
    t2c_pin_model pins (.clk_in(clk), .count_pin_out(count_pin), .trig_pin_out(trig_pin));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // baud tick tally
    always @(posedge clk) begin
        if (rx_tick === 1'b1) rx_cnt++;
        if (tx_tick === 1'b1) tx_cnt++;
    end

    // one transfer; an idle edge first so no signal is driven twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [7:0] rq, output logic re);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rq = prdata[7:0];
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, q, e);
    endtask
    task automatic w16(input logic [11:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 12'h004, v[15:8]);
    endtask
    task automatic chk_rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00, q, e);
        `T2C_CHK(q, x)
    endtask
    task automatic chk_irq(input logic x);
        @(posedge clk);
        `T2C_CHK(irq, x)
    endtask
    // spacing of machine-cycle pulses, skipping one pulse after a change
    task automatic gap(input int x);
        int k;
        k = 0;
        @(posedge clk iff mc === 1'b1);
        @(posedge clk iff mc === 1'b1);
        do begin @(posedge clk); k++; end while (mc !== 1'b1 && k < 40);
        `T2C_CHK(k, x)
    endtask

    task automatic summarize();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    initial begin
        {rst_n, psel, penable, pwrite, t1_ovf, mode13} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            apb(1'b0, rows[i].ra, 8'h00, q, e);
            `T2C_CHK(q, rows[i].exp)
            `T2C_CHK(e, rows[i].err)
        end
        // overflow in timer mode with clock out
        wr(MD, 8'h02);
        chk_irq(1'b0);
        `T2C_CHK(clk_oe, 1'b1)
        w16(RL, 16'hFFF0);
        w16(CL, 16'hFFFE);
        wr(MK, 8'h01);
        wr(CT, 8'h04);
        n = 0;
        while (irq !== 1'b1 && n < 400) begin @(posedge clk); n++; end
        `T2C_CHK(clk_out, 1'b1)
        chk_rd(CT, 8'h84);
        wr(ST, 8'h01);
        chk_irq(1'b0);
        chk_rd(CT, 8'h04);
        wr(CT, 8'h00);
        wr(MD, 8'h00);
        // capture on trigger, then the flag with and without up/down mode
        w16(CL, 16'h1234);
        wr(CT, 8'h0F);
        pins.fall_trigger();
        chk_rd(RL, 8'h34);
        chk_rd(RH, 8'h12);
        chk_rd(CT, 8'h4F);
        wr(MK, 8'h02);
        chk_irq(1'b1);
        wr(MD, 8'h01);
        chk_irq(1'b0);
        wr(MD, 8'h00);
        chk_irq(1'b1);
        wr(ST, 8'h02);
        chk_irq(1'b0);
        // reload on trigger
        wr(CT, 8'h0E);
        w16(RL, 16'h00AB);
        pins.fall_trigger();
        chk_rd(CL, 8'hAB);
        chk_rd(CT, 8'h4E);
        // trigger ignored when disabled, then counting up on five count-pin edges
        wr(CT, 8'h06);
        w16(CL, 16'h1234);
        pins.fall_trigger();
        chk_rd(CT, 8'h06);
        pins.pulse_count(5);
        chk_rd(CL, 8'h39);
        // up/down mode: a low trigger level counts down
        wr(MD, 8'h01);
        pins.set_trigger(1'b0);
        pins.pulse_count(2);
        chk_rd(CL, 8'h37);
        pins.set_trigger(1'b1);
        wr(MD, 8'h00);
        wr(CT, 8'h02);
        pins.pulse_count(3);
        chk_rd(CL, 8'h37);
        // timer 2 clocking the serial port
        mode13 <= 1'b1;
        w16(RL, 16'hFFFE);
        w16(CL, 16'hFFFF);
        r0 = rx_cnt;
        t0 = tx_cnt;
        wr(CT, 8'h3F);
        pins.pulse_count(2);
        pins.fall_trigger();
        chk_rd(CL, 8'hFF);
        chk_rd(CT, 8'h3F);
        `T2C_CHK(rx_cnt - r0, 1)
        `T2C_CHK(tx_cnt - t0, 1)
        wr(CT, 8'h20);
        r0 = rx_cnt;
        t0 = tx_cnt;
        t1_ovf <= 1'b1;
        @(posedge clk);
        t1_ovf <= 1'b0;
        repeat (4) @(posedge clk);
        `T2C_CHK(rx_cnt - r0, 0)
        `T2C_CHK(tx_cnt - t0, 1)
        // machine cycle length at both speeds
        gap(12);
        wr(CK, 8'h01);
        gap(6);
        // reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_rd(CT, 8'h00);
        chk_rd(CK, 8'h00);
        summarize();
    end
endmodule

`default_nettype wire
